// ==== verilog/sram_ctrl_pkg.sv ====
// Purpose: Constants for the asynchronous byte-wide static memory controller.
// Assumes: 40 MHz controller clock, 25 ns period.
// Notes:   Timing figures are in nanoseconds; cycle counts other than HOLD_CYCLES derive from them.
package sram_ctrl_pkg;
    localparam int CLK_PERIOD_NS    = 25;
    // Slowest speed grade figures, all minimum times.
    localparam int READ_CYCLE_NS    = 20;
    localparam int WE_PULSE_OEH_NS  = 12;
    localparam int WE_PULSE_OEL_NS  = 17;
    localparam int DATA_SETUP_NS    = 9;
    localparam int WRITE_CYCLE_NS   = 20;
    localparam int ADDR_SETUP_NS    = 0;

    function automatic int ns_to_cycles_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cycles_min

    localparam int READ_CYCLES      = ns_to_cycles_min(READ_CYCLE_NS);
    localparam int WE_OEH_CYCLES    = ns_to_cycles_min(WE_PULSE_OEH_NS);
    localparam int WE_OEL_CYCLES    = ns_to_cycles_min(WE_PULSE_OEL_NS);
    localparam int SETUP_CYCLES     = ns_to_cycles_min(ADDR_SETUP_NS);
    localparam int HOLD_CYCLES      = 1;
    localparam int CNT_W            = 4;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_READ   = 3'b010,
        ST_WRITE  = 3'b011,
        ST_HOLD   = 3'b100
    } sram_state_t;
endpackage : sram_ctrl_pkg

// ==== verilog/sram_ctrl.sv ====
// Purpose: Host-side controller for an asynchronous byte-wide static memory.
// Assumes: One 40 MHz clock; memory pins are registered outputs.
// Notes:   One access at a time; req_ready is high only in idle.
//          Writes end on the strobe; chip select rises one cycle later.
//          Reset aborts an access and parks every strobe high.
//
// Behaviour
// - Write strobe stays high through every read access.
// - Address is stable before chip select falls for a read.
// - Write starts with chip select and strobe both active; first rising one ends it.
// - Write data held stable across the terminating strobe edge.
// - Longer strobe minimum used when output enable stays low in a write; both round to one cycle.
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl
    import sram_ctrl_pkg::*;
#(
    parameter int ADDR_W     = 20,
    parameter int DATA_W     = 8,
    parameter bit OE_IN_WRITE = 1'b0
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output logic                   rsp_valid,
    output logic      [DATA_W-1:0] rsp_rdata,
    output logic      [ADDR_W-1:0] mem_addr,
    output logic                   mem_ce_n,
    output logic                   mem_oe_n,
    output logic                   mem_we_n,
    input  wire logic [DATA_W-1:0] mem_data_in,
    output logic      [DATA_W-1:0] mem_data_out,
    output logic                   mem_data_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks. The counter must hold every phase length.
    // A phase that does not fit would wrap the counter and end early; a read, strobe or hold phase that wraps to zero never ends.

    if (ADDR_W < 1) begin : g_bad_addr_w
        $error("sram_ctrl: ADDR_W must be at least 1");
    end
    if (DATA_W < 1) begin : g_bad_data_w
        $error("sram_ctrl: DATA_W must be at least 1");
    end
    if (READ_CYCLES < 1 || READ_CYCLES >= (1 << CNT_W)) begin : g_bad_read
        $error("sram_ctrl: read phase does not fit the counter");
    end
    if (WE_OEL_CYCLES < 1 || WE_OEL_CYCLES >= (1 << CNT_W)) begin : g_bad_we
        $error("sram_ctrl: strobe phase does not fit the counter");
    end
    if (WE_OEH_CYCLES < 1 || WE_OEH_CYCLES >= (1 << CNT_W)) begin : g_bad_weh
        $error("sram_ctrl: strobe phase does not fit the counter");
    end
    if (SETUP_CYCLES < 1 || HOLD_CYCLES < 1
        || SETUP_CYCLES >= (1 << CNT_W)
        || HOLD_CYCLES >= (1 << CNT_W)) begin : g_bad_phase
        $error("sram_ctrl: setup or hold phase does not fit the counter");
    end

    localparam logic [CNT_W-1:0] READ_CNT  = CNT_W'(READ_CYCLES);
    localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(SETUP_CYCLES);
    localparam logic [CNT_W-1:0] HOLD_CNT  = CNT_W'(HOLD_CYCLES);
    // A phase ends when the down counter shows its last cycle.
    localparam logic [CNT_W-1:0] LAST_CNT  = CNT_W'(1);
    // With output enable low in a write the longer strobe applies.
    localparam logic [CNT_W-1:0] WE_CNT    = OE_IN_WRITE ?
        CNT_W'(WE_OEL_CYCLES) : CNT_W'(WE_OEH_CYCLES);

    sram_state_t      state;
    sram_state_t      next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             is_write;
    logic             take;

    ////////////////////////////////////////////////////////////////////////
    // State decoding used only by the pin registers, not by the sequencer.

    // Chip select is low in every phase that touches the memory.
    function automatic logic selects_memory(input sram_state_t s);
        return (s == ST_READ) || (s == ST_WRITE) || (s == ST_HOLD);
    endfunction : selects_memory

    // The write byte is driven from the strobe phase through the hold.
    function automatic logic carries_wdata(input sram_state_t s);
        return (s == ST_WRITE) || (s == ST_HOLD);
    endfunction : carries_wdata

    // Output enable is low for reads, and in writes only when configured.
    function automatic logic enables_output(input sram_state_t s);
        return (s == ST_READ) || (OE_IN_WRITE && s == ST_WRITE);
    endfunction : enables_output

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.

    // Each phase loads the counter with its length in cycles and leaves
    // when the counter shows its last cycle, so every phase lasts at least
    // one full clock even when its minimum time is far below a period.
    always_comb begin
        next_state = state;
        next_cnt   = (cnt != '0) ? cnt - 1'b1 : cnt;
        unique case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = ST_SETUP;
                    next_cnt   = SETUP_CNT;
                end
            end
            ST_SETUP: begin
                // The address settles one cycle before chip select falls.
                if (cnt <= LAST_CNT) begin
                    next_state = is_write ? ST_WRITE : ST_READ;
                    next_cnt   = is_write ? WE_CNT : READ_CNT;
                end
            end
            ST_READ: begin
                // Chip select and output enable rise together after a read.
                if (cnt == LAST_CNT) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                // The strobe phase length depends on the output enable mode.
                if (cnt == LAST_CNT) begin
                    next_state = ST_HOLD;
                    next_cnt   = HOLD_CNT;
                end
            end
            ST_HOLD: begin
                // Chip select and data stay one cycle after the strobe rises.
                if (cnt == LAST_CNT) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    assign req_ready = (state == ST_IDLE);
    // A request is taken on the edge at which it meets an idle sequencer.
    assign take      = req_valid && req_ready;

    ////////////////////////////////////////////////////////////////////////
    // Address and data capture; held for the whole access.
    // The registers change only at a take, at least a cycle before chip
    // select falls, so the memory always sees a settled address.

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_addr     <= '0;
            mem_data_out <= '0;
            is_write     <= 1'b0;
        end else if (take) begin
            mem_addr     <= req_addr;
            mem_data_out <= req_wdata;
            is_write     <= req_write;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory strobes. Chip select falls one cycle after the address is set.
    // Every pin is registered from next_state, so each one changes on a
    // clock edge and never glitches between phases.

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_ce_n    <= 1'b1;
            mem_oe_n    <= 1'b1;
            mem_we_n    <= 1'b1;
            mem_data_oe <= 1'b0;
        end else begin
            mem_ce_n    <= !selects_memory(next_state);
            // Strobe low only in the write phase; the rise ends the write.
            mem_we_n    <= !(next_state == ST_WRITE);
            // Output enable stays high in writes unless the mode keeps it.
            mem_oe_n    <= !enables_output(next_state);
            // Data driven through the strobe and hold phases of a write.
            mem_data_oe <= is_write && carries_wdata(next_state);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read capture. The byte is sampled on the last cycle of the read.
    // By then chip select and output enable have been low for the whole
    // read phase, which covers the access time of the slowest grade.
    // The byte stays in rsp_rdata until the next read completes or reset clears it.

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (state == ST_READ && cnt == LAST_CNT) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= mem_data_in;
            end
        end
    end

endmodule : sram_ctrl
`default_nettype wire

// ==== test/sram_ctrl_props.sv ====
// Purpose: Pin-level checks for sram_ctrl.
// Assumes: OE_IN_WRITE left at 0.
// Notes:   Sees only top-level ports.
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_props (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_write,
    input wire logic        rsp_valid,
    input wire logic [19:0] mem_addr,
    input wire logic        mem_ce_n,
    input wire logic        mem_oe_n,
    input wire logic        mem_we_n,
    input wire logic [7:0]  mem_data_out,
    input wire logic        mem_data_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic rd = req_valid && req_ready && !req_write;
    wire logic wr = req_valid && req_ready && req_write;
    property p_rw; rd |=> mem_we_n [*2]; endproperty
    a_rw: assert property (p_rw) else $error("we low in read");
    property p_ad; $fell(mem_ce_n) |-> $stable(mem_addr); endproperty
    a_ad: assert property (p_ad) else $error("addr moved");
    property p_ov; $fell(mem_we_n) |-> !mem_ce_n && mem_data_oe; endproperty
    a_ov: assert property (p_ov) else $error("no overlap");
    property p_we; $rose(mem_we_n) |-> !mem_ce_n ##1 mem_ce_n; endproperty
    a_we: assert property (p_we) else $error("bad end");
    property p_wd; $rose(mem_we_n) |-> $stable(mem_data_out); endproperty
    a_wd: assert property (p_wd) else $error("data moved");
    property p_rs; rd |-> ##[1:3] rsp_valid; endproperty
    a_rs: assert property (p_rs) else $error("no answer");
    property p_oe; !mem_we_n |-> mem_oe_n; endproperty
    a_oe: assert property (p_oe) else $error("oe in write");
    property p_ct; mem_data_oe |-> mem_oe_n; endproperty
    a_ct: assert property (p_ct) else $error("contention");
    property p_wp; $fell(mem_we_n) |-> !mem_we_n ##1 mem_we_n; endproperty
    a_wp: assert property (p_wp) else $error("strobe width");
    property p_rdy; wr |=> !req_ready [*3] ##1 req_ready; endproperty
    a_rdy: assert property (p_rdy) else $error("write length");
endmodule : sram_ctrl_props
bind sram_ctrl sram_ctrl_props sram_ctrl_props_i (.clk, .reset_n,
    .req_valid, .req_ready, .req_write, .rsp_valid, .mem_addr, .mem_ce_n,
    .mem_oe_n, .mem_we_n, .mem_data_out, .mem_data_oe);
`default_nettype wire

// ==== test/sram_model.sv ====
// Purpose: Behavioural byte-wide static memory.
// Assumes: Pins as seen on the shared wire.
// Notes:   Released lines show the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module sram_model (
    input wire logic [19:0] mem_addr,
    input wire logic        mem_ce_n,
    input wire logic        mem_oe_n,
    input wire logic        mem_we_n,
    input wire logic [7:0]  mem_data_in,
    output logic     [7:0]  dq
);
    logic [7:0] mem [0:20'hFFFFF];
    logic [7:0] last = 8'h00;
    wire logic en = !mem_ce_n && !mem_oe_n && mem_we_n;
    // Data is taken at whichever strobe ends the overlap.
    always @(posedge mem_we_n or posedge mem_ce_n)
        if (!mem_ce_n || !mem_we_n) mem[mem_addr] = mem_data_in;
    always @(en or mem_addr) if (en) last = mem[mem_addr];
    assign dq = en ? last : ~last;
endmodule : sram_model
`default_nettype wire

// ==== test/async_sram_write_read_port_tb_top.sv ====
// Purpose: Self-checking bench for sram_ctrl.
// Assumes: Default parameters.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module async_sram_write_read_port_tb_top;
    logic clk = 0, reset_n = 0, req_valid = 0, req_write = 0;
    logic [19:0] req_addr = 20'h0, mem_addr;
    logic [7:0] req_wdata = 8'h0, rsp_rdata, mem_data_out, dq;
    logic req_ready, rsp_valid, mem_ce_n, mem_oe_n, mem_we_n, mem_data_oe;
    wire logic [7:0] mem_data_in = mem_data_oe ? mem_data_out : dq;
    int fail_count = 0, total_checks = 0, cyc = 0;
    always #12.5 clk = ~clk;
    sram_ctrl sram_ctrl_i (.clk, .reset_n, .req_valid, .req_ready,
        .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .mem_addr,
        .mem_ce_n, .mem_oe_n, .mem_we_n, .mem_data_in, .mem_data_out,
        .mem_data_oe);
    sram_model sram_model_i (.mem_addr, .mem_ce_n, .mem_oe_n, .mem_we_n,
        .mem_data_in, .dq);
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic req(logic w, logic [19:0] a, logic [7:0] d);
        @(posedge clk) #1;
        req_valid = 1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        while (req_ready !== 1'b1) @(posedge clk) #1;
        @(posedge clk) #1;
        req_valid = 0;
    endtask : req
    task automatic rd(logic [19:0] a, logic [7:0] e);
        req(0, a, 8'h00);
        repeat (3) if (rsp_valid !== 1'b1) @(posedge clk) #1;
        chk("rsp_valid", 8'h01, rsp_valid);
        chk("rsp_rdata", e, rsp_rdata);
    endtask : rd
    task automatic t_readback;
        for (int i = 0; i < 3; i++) req(1, 20'hFFFFF * i, 8'h3C + i);
        for (int i = 0; i < 3; i++) rd(20'hFFFFF * i, 8'h3C + i);
    endtask : t_readback
    task automatic t_overwrite;
        req(1, 20'h5A5A5, 8'h11);
        req(1, 20'h5A5A5, 8'hEE);
        rd(20'h5A5A5, 8'hEE);
    endtask : t_overwrite
    task automatic t_reset;
        logic [7:0] pins;
        req(1, 20'h00123, 8'h77);
        repeat (2) @(posedge clk) #1;
        pins = {mem_ce_n, mem_oe_n, mem_we_n, mem_data_oe};
        chk("hold pins", 8'h07, pins);
        reset_n = 0;
        #1 pins = {mem_ce_n, mem_oe_n, mem_we_n, mem_data_oe};
        chk("reset pins", 8'h0E, pins);
        chk("req_ready", 8'h01, req_ready);
        @(posedge clk) #1 reset_n = 1;
        rd(20'h00000, 8'h3C);
        rd(20'h00123, 8'h77);
    endtask : t_reset
    task test_done;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    always @(posedge clk) if (++cyc == 3000) begin
        fail_count++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge clk);
        #1 reset_n = 1;
        t_readback();
        t_overwrite();
        t_reset();
        test_done();
    end
endmodule : async_sram_write_read_port_tb_top
`default_nettype wire
